// ===== rtl/stg_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-generator sine tone unit with constant output and attenuator.
// Assumes: Byte register port, 10 MHz clock, pseudo-random samples on sys_clk.
// Notes:   One sample per cycle while running; a full FIFO stalls the phases.
// Operation
// - Run bit 0 stops the generator, 1 runs it; it resets to 0.
// - Source code 0 sum, 1 first, 2 second, 3 ramp to constant.
// - First frequency word is high and low byte; frequency is word*clock/2^24.
// - Second frequency word is built the same way from its own bytes.
// - Force bit outputs one of four fixed constants chosen by the level field.
// - Constant values bypass the attenuator.
// - Four-bit attenuation alternates -2.5 and -3.5 dB steps down to -44.5.
// - An enabled pseudo-random source takes priority over the tone.
//////////////////////////////////////////////////////////////////////////////
module stg_top
  import stg_pkg::*;
(
  // Clock and reset.
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  // Register port.
  input  wire logic [15:0]     reg_addr,
  input  wire logic            reg_wr_en,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_rd_en,
  output logic [7:0]           reg_rdata,
  output logic                 reg_rvalid,
  // Pseudo-random sources.
  input  wire logic [1:0]      prbs_enable,
  input  wire logic [23:0]     prbs_sample,
  // Sample stream.
  output logic                 smp_valid,
  output stg_sample_type       smp_data,
  input  wire logic            smp_ready,
  // Status.
  output logic                 tone_running
);

  stg_state_type  st_ff;
  stg_state_type  nxt_st;
  logic [23:0]    freq_one;
  logic [23:0]    freq_two;
  logic [23:0]    sine_one;
  logic [23:0]    sine_two;
  logic [23:0]    ramp_wave;
  logic [23:0]    tone_raw;
  logic [23:0]    ramp_next;
  logic           prbs_take;
  logic           fifo_in_valid;
  logic           fifo_in_ready;
  logic           advance;
  stg_sample_type fifo_in_data;
  logic [7:0]     rd_mux;

  //////////////////////////////////////////////////////////////////////////////
  // Sample path.
  assign freq_one = {8'h00, st_ff.first_freq_high_byte, st_ff.first_freq_low_byte};
  assign freq_two = {8'h00, st_ff.second_freq_high_byte, st_ff.second_freq_low_byte};
  assign sine_one  = stg_sine(st_ff.phase_one);
  assign sine_two  = stg_sine(st_ff.phase_two);
  assign ramp_wave = stg_sine(st_ff.phase_one - PHASE_QUARTER);
  assign ramp_next = st_ff.phase_one + freq_one;
  assign prbs_take = |prbs_enable;

  always_comb
  begin
    unique case (st_ff.tone_source_select)
      SRC_SUM:  tone_raw = sine_one + sine_two;
      SRC_ONE:  tone_raw = sine_one;
      SRC_TWO:  tone_raw = sine_two;
      SRC_RAMP: tone_raw = ramp_wave;
    endcase
  end

  always_comb
  begin
    fifo_in_data = '0;
    if (prbs_take)
    begin
      fifo_in_data.value = prbs_sample;
    end
    else if (st_ff.force_constant_output)
    begin
      fifo_in_data.value       = stg_dc_level(st_ff.constant_level_select);
      fifo_in_data.is_constant = 1'b1;
    end
    else
    begin
      fifo_in_data.value = stg_atten(tone_raw, st_ff.gain_code);
    end
  end

  // A full FIFO stalls the phases rather than dropping samples, so the tone
  // stays continuous at the cost of following the consumer's pace.
  assign fifo_in_valid = prbs_take || st_ff.tone_run_control;
  assign advance       = st_ff.tone_run_control && !prbs_take && fifo_in_ready;

  stg_fifo #(
    .WIDTH ($bits(stg_sample_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (smp_valid),
    .out_data  (smp_data),
    .out_ready (smp_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registers and phase state.
  always_comb
  begin
    unique case (reg_addr)
      ADDR_RUN_SOURCE: rd_mux = {st_ff.tone_run_control, st_ff.ramp_done, 4'h0,
                                 st_ff.tone_source_select};
      ADDR_F1_LOW:     rd_mux = st_ff.first_freq_low_byte;
      ADDR_F1_HIGH:    rd_mux = st_ff.first_freq_high_byte;
      ADDR_F2_LOW:     rd_mux = st_ff.second_freq_low_byte;
      ADDR_F2_HIGH:    rd_mux = st_ff.second_freq_high_byte;
      ADDR_CONST_OUT:  rd_mux = {2'b00, st_ff.constant_level_select, 3'b000,
                                 st_ff.force_constant_output};
      ADDR_ATTEN:      rd_mux = {4'h0, st_ff.gain_code};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.rvalid = reg_rd_en;
    if (reg_rd_en)
    begin
      nxt_st.rdata = rd_mux;
    end
    if (reg_wr_en)
    begin
      unique case (reg_addr)
        ADDR_RUN_SOURCE:
        begin
          nxt_st.tone_run_control   = reg_wdata[RUN_BIT];
          nxt_st.tone_source_select = reg_wdata[SRC_LSB +: 2];
        end
        ADDR_F1_LOW:  nxt_st.first_freq_low_byte   = reg_wdata;
        ADDR_F1_HIGH: nxt_st.first_freq_high_byte  = reg_wdata;
        ADDR_F2_LOW:  nxt_st.second_freq_low_byte  = reg_wdata;
        ADDR_F2_HIGH: nxt_st.second_freq_high_byte = reg_wdata;
        ADDR_CONST_OUT:
        begin
          nxt_st.constant_level_select = reg_wdata[LVL_LSB +: 2];
          nxt_st.force_constant_output = reg_wdata[FORCE_BIT];
        end
        ADDR_ATTEN:   nxt_st.gain_code = reg_wdata[GAIN_LSB +: 4];
        default:      ;
      endcase
    end
    if (!st_ff.tone_run_control)
    begin
      nxt_st.phase_one = '0;
      nxt_st.phase_two = '0;
      nxt_st.ramp_done = 1'b0;
    end
    else if (advance)
    begin
      nxt_st.phase_two = st_ff.phase_two + freq_two;
      if (st_ff.tone_source_select != SRC_RAMP)
      begin
        nxt_st.phase_one = ramp_next;
      end
      else if (!st_ff.phase_one[23])
      begin
        // The ramp stops exactly on the half turn so the held level is exact.
        nxt_st.phase_one = ramp_next[23] ? PHASE_HALF : ramp_next;
      end
      nxt_st.ramp_done = st_ff.phase_one[23] && (st_ff.tone_source_select == SRC_RAMP);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      st_ff <= ST_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata    = st_ff.rdata;
  assign reg_rvalid   = st_ff.rvalid;
  assign tone_running = st_ff.tone_run_control;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_stop_no_push: assert property (
    (!st_ff.tone_run_control && !prbs_take) |-> !fifo_in_valid ##1
      (st_ff.phase_one == 24'h00_0000 && st_ff.phase_two == 24'h00_0000))
    else $error("Stopped generator pushed a sample.");

  a_run_bit_write: assert property (
    (reg_wr_en && reg_addr == ADDR_RUN_SOURCE) |=>
      (tone_running == $past(reg_wdata[RUN_BIT])))
    else $error("Run bit did not follow the write.");

  a_source_one_only: assert property (
    (st_ff.tone_source_select == SRC_ONE && st_ff.gain_code == 4'h0 && !prbs_take &&
     !st_ff.force_constant_output) |-> fifo_in_data.value == sine_one)
    else $error("Source one did not output the first sine.");

  a_freq_one_step: assert property (
    (advance && st_ff.tone_source_select != SRC_RAMP) |=>
      (st_ff.phase_one == 24'($past(st_ff.phase_one) + $past(freq_one))))
    else $error("First phase did not step by its word.");

  a_freq_two_step: assert property (
    advance |=> (st_ff.phase_two == 24'($past(st_ff.phase_two) + $past(freq_two))))
    else $error("Second phase did not step by its word.");

  a_dc_level_out: assert property (
    (st_ff.force_constant_output && !prbs_take && st_ff.constant_level_select == 2'h2)
      |-> fifo_in_data.value == 24'h80_0000 && fifo_in_data.is_constant)
    else $error("Forced level two is not minus full scale.");

  a_dc_no_gain: assert property (
    (st_ff.force_constant_output && !prbs_take && st_ff.gain_code == 4'hF &&
     st_ff.constant_level_select == 2'h1) |-> fifo_in_data.value == 24'h40_0000)
    else $error("Attenuation was applied to a constant.");

  a_gain_two_half: assert property (
    (st_ff.gain_code == 4'h2 && !prbs_take && !st_ff.force_constant_output)
      |-> fifo_in_data.value == 24'($signed(tone_raw) >>> 1))
    else $error("Gain code two is not a halving.");

  a_prbs_priority: assert property (
    prbs_take |-> (fifo_in_valid && !advance && fifo_in_data.value == prbs_sample))
    else $error("Tone was not displaced by the pseudo-random source.");

  a_phase_held_stop: assert property (
    (st_ff.tone_run_control && !fifo_in_ready) ##1 st_ff.tone_run_control
      |-> $stable(st_ff.phase_two))
    else $error("Phase moved while the FIFO was full.");

  c_sum_running: cover property (
    st_ff.tone_run_control && st_ff.tone_source_select == SRC_SUM && advance);
  c_ramp_settled: cover property (st_ff.ramp_done);
  c_fifo_full: cover property (st_ff.tone_run_control && !fifo_in_ready);
  c_prbs_taken: cover property (prbs_take && fifo_in_ready);

endmodule // stg_top

// ===== include/stg_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants, types and helper functions of the sine tone unit.
// Assumes: Byte-wide register port on the control bus, one 10 MHz clock.
// Notes:   Phase is 24 bits wide, so frequency = word * clock / 2^24.
//////////////////////////////////////////////////////////////////////////////
package stg_pkg;

  // Register offsets on the control bus.
  localparam logic [15:0] ADDR_RUN_SOURCE = 16'h0C81;
  localparam logic [15:0] ADDR_F1_LOW     = 16'h0C82;
  localparam logic [15:0] ADDR_F1_HIGH    = 16'h0C83;
  localparam logic [15:0] ADDR_F2_LOW     = 16'h0C84;
  localparam logic [15:0] ADDR_F2_HIGH    = 16'h0C85;
  localparam logic [15:0] ADDR_CONST_OUT  = 16'h0C89;
  localparam logic [15:0] ADDR_ATTEN      = 16'h0C8A;

  // Field positions.
  localparam int RUN_BIT       = 7;
  localparam int RAMP_DONE_BIT = 6;
  localparam int SRC_LSB       = 0;
  localparam int LVL_LSB       = 4;
  localparam int FORCE_BIT     = 0;
  localparam int GAIN_LSB      = 0;

  // Values after reset.
  localparam logic [7:0] RST_F1_LOW  = 8'h55;
  localparam logic [7:0] RST_F1_HIGH = 8'h00;
  localparam logic [7:0] RST_F2_LOW  = 8'h00;
  localparam logic [7:0] RST_F2_HIGH = 8'h40;

  // Source select codes.
  localparam logic [1:0] SRC_SUM   = 2'h0;
  localparam logic [1:0] SRC_ONE   = 2'h1;
  localparam logic [1:0] SRC_TWO   = 2'h2;
  localparam logic [1:0] SRC_RAMP  = 2'h3;

  // Constant output levels.
  localparam logic [23:0] DC_ZERO     = 24'h00_0000;
  localparam logic [23:0] DC_POS_HALF = 24'h40_0000;
  localparam logic [23:0] DC_NEG_FULL = 24'h80_0000;
  localparam logic [23:0] DC_NEG_HALF = 24'hC0_0000;

  // Phase constants.
  localparam logic [23:0] PHASE_QUARTER = 24'h40_0000;
  localparam logic [23:0] PHASE_HALF    = 24'h80_0000;

  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [23:0] value;
    logic        is_constant;
  } stg_sample_type;

  typedef struct packed {
    logic        tone_run_control;
    logic [1:0]  tone_source_select;
    logic [7:0]  first_freq_low_byte;
    logic [7:0]  first_freq_high_byte;
    logic [7:0]  second_freq_low_byte;
    logic [7:0]  second_freq_high_byte;
    logic [1:0]  constant_level_select;
    logic        force_constant_output;
    logic [3:0]  gain_code;
    logic [23:0] phase_one;
    logic [23:0] phase_two;
    logic        ramp_done;
    logic [7:0]  rdata;
    logic        rvalid;
  } stg_state_type;

  localparam stg_state_type ST_RESET = '{
    tone_run_control:      1'b0,
    tone_source_select:    SRC_SUM,
    first_freq_low_byte:   RST_F1_LOW,
    first_freq_high_byte:  RST_F1_HIGH,
    second_freq_low_byte:  RST_F2_LOW,
    second_freq_high_byte: RST_F2_HIGH,
    constant_level_select: 2'h0,
    force_constant_output: 1'b0,
    gain_code:             4'h0,
    phase_one:             24'h00_0000,
    phase_two:             24'h00_0000,
    ramp_done:             1'b0,
    rdata:                 8'h00,
    rvalid:                1'b0
  };

  // Parabolic half-wave approximation; peak reaches a quarter of full scale
  // so that the summed mode can never overflow.
  function automatic logic [23:0] stg_sine(input logic [23:0] ph);
    logic [22:0] x;
    logic [22:0] prod;
    logic [23:0] mag;
    x    = {12'h000, ph[22:12]};
    prod = x * (23'h00_0800 - x);
    mag  = {2'b00, prod[20:0], 1'b0};
    return ph[23] ? 24'(-mag) : mag;
  endfunction

  // Even codes halve per step (-6 dB), odd codes add a 0.75 factor (-2.5 dB).
  function automatic logic [23:0] stg_atten(input logic [23:0] s, input logic [3:0] code);
    logic signed [23:0] sh;
    sh = $signed(s) >>> code[3:1];
    if (code[0])
    begin
      sh = sh - (sh >>> 2);
    end
    return sh;
  endfunction

  function automatic logic [23:0] stg_dc_level(input logic [1:0] lvl);
    logic [23:0] v;
    unique case (lvl)
      2'h0: v = DC_ZERO;
      2'h1: v = DC_POS_HALF;
      2'h2: v = DC_NEG_FULL;
      2'h3: v = DC_NEG_HALF;
    endcase
    return v;
  endfunction

endpackage

// ===== rtl/stg_fifo.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Sample FIFO with a registered output stage.
// Assumes: Same clock on both sides, synchronous active-low reset.
// Notes:   Holds DEPTH words in storage plus one in the output register.
//////////////////////////////////////////////////////////////////////////////
module stg_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Fill side.
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side.
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic [WIDTH-1:0]            out_data;
    logic                        out_valid;
  } stg_fifo_state_type;

  stg_fifo_state_type st_ff;
  stg_fifo_state_type nxt_st;
  logic               push;
  logic               load;

  //////////////////////////////////////////////////////////////////////////////
  assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = st_ff.out_valid;
  assign out_data  = st_ff.out_data;

  always_comb
  begin
    nxt_st = st_ff;
    push   = in_valid && in_ready;
    if (st_ff.out_valid && out_ready)
    begin
      nxt_st.out_valid = 1'b0;
    end
    load = !nxt_st.out_valid && (st_ff.cnt != '0);
    if (push)
    begin
      nxt_st.mem[st_ff.wr] = in_data;
      nxt_st.wr            = st_ff.wr + 1'b1;
    end
    if (load)
    begin
      nxt_st.out_data  = st_ff.mem[st_ff.rd];
      nxt_st.out_valid = 1'b1;
      nxt_st.rd        = st_ff.rd + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

endmodule // stg_fifo

// ===== verif/stg_sink.sv
////////////////////////////////////////
// Purpose: Consumer model of the audio path that takes generated samples.
// Assumes: Same clock as the tone unit, valid/ready handshake.
// Notes:   Stall holds ready low so the FIFO can be filled until it refuses.
////////////////////////////////////////
module stg_sink
  import stg_pkg::*;
(
  // Clock.
  input  wire logic            sys_clk,
  // Sample stream.
  input  wire logic            smp_valid,
  input  wire stg_sample_type  smp_data,
  output logic                 smp_ready,
  // Control from the bench.
  input  wire logic            stall
);
  timeunit 1ns;
  timeprecision 1ns;

  stg_sample_type got_q[$];

  assign smp_ready = !stall;

  // Every accepted sample is queued so that the bench sees gaps or drops.
  always @(posedge sys_clk)
  begin
    if (smp_valid && smp_ready)
    begin
      got_q.push_back(smp_data);
    end
  end
endmodule // stg_sink

// ===== verif/testbench.sv
////////////////////////////////////////
// Purpose: Self-checking bench of the sine tone unit.
// Assumes: Register port with one-cycle strobes, sink model on the stream.
// Notes:   Expected samples come from a local model of phase and attenuation.
////////////////////////////////////////
module testbench import stg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic           sys_clk;
  logic           resetn;
  logic [15:0]    reg_addr;
  logic           reg_wr_en;
  logic [7:0]     reg_wdata;
  logic           reg_rd_en;
  logic [7:0]     reg_rdata;
  logic           reg_rvalid;
  logic [1:0]     prbs_enable;
  logic [23:0]    prbs_sample;
  logic           smp_valid;
  stg_sample_type smp_data;
  logic           smp_ready;
  logic           tone_running;
  logic           stall;
  stg_sample_type s;
  logic [7:0]     d;
  logic [23:0]    ev;
  int             error_cnt;
  int             tests_run;

  localparam logic [15:0] RA [7] = '{ADDR_RUN_SOURCE, ADDR_F1_LOW, ADDR_F1_HIGH,
    ADDR_F2_LOW, ADDR_F2_HIGH, ADDR_CONST_OUT, ADDR_ATTEN};
  localparam logic [7:0] RV [7] = '{8'h00, 8'h55, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};
  localparam logic [7:0] WV [7] = '{8'h43, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'hFF, 8'hFF};
  localparam logic [7:0] BV [7] = '{8'h03, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h31, 8'h0F};
  localparam logic [23:0] DCV [4] = '{DC_ZERO, DC_POS_HALF, DC_NEG_FULL, DC_NEG_HALF};

  stg_top dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .prbs_enable(prbs_enable),
    .prbs_sample(prbs_sample), .smp_valid(smp_valid), .smp_data(smp_data),
    .smp_ready(smp_ready), .tone_running(tone_running));

  stg_sink snk (.sys_clk(sys_clk), .smp_valid(smp_valid), .smp_data(smp_data),
    .smp_ready(smp_ready), .stall(stall));

  ////////////////////////////////////////
  function automatic logic [23:0] ref_sine(input logic [23:0] p);
    logic [23:0] m;
    m = 24'(p[22:12]) * (24'd2048 - 24'(p[22:12])) * 24'd2;
    return p[23] ? -m : m;
  endfunction

  function automatic logic [23:0] ref_att(input logic [23:0] v, input logic [3:0] c);
    logic signed [23:0] h;
    h = $signed(v) >>> c[3:1];
    if (c[0])
    begin
      h = h - (h >>> 2);
    end
    return h;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask

  // The answer stands one cycle only, so it is taken at the first sight of it.
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    int n;
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 8)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 8)
    begin
      error_cnt++;
      print_verdict();
    end
    v = reg_rdata;
  endtask

  task automatic take(output stg_sample_type v);
    int n;
    n = 0;
    while (snk.got_q.size() == 0 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 200)
    begin
      error_cnt++;
      print_verdict();
    end
    v = snk.got_q.pop_front();
  endtask

  // Stops the unit, lets the FIFO drain and checks that nothing more arrives.
  task automatic quiet();
    stall = 1'b0;
    prbs_enable = 2'b00;
    wr(ADDR_RUN_SOURCE, 8'h00);
    repeat (30) @(negedge sys_clk);
    snk.got_q.delete();
    repeat (5) @(negedge sys_clk);
    chk(32'(tone_running), 32'h0);
    chk(32'(snk.got_q.size()), 32'h0);
  endtask

  ////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    {reg_wr_en, reg_rd_en, stall} = 3'b000;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    prbs_enable = 2'b00;
    prbs_sample = 24'h00_0000;
    resetn = 1'b0;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rd(RA[i], d);
      chk(32'(d), 32'(RV[i]));
      wr(RA[i], WV[i]);
      rd(RA[i], d);
      chk(32'(d), 32'(BV[i]));
    end
    wr(16'h0C86, 8'hFF);
    rd(16'h0C86, d);
    chk(32'(d), 32'h0);
    $display("test registers done");
    wr(ADDR_ATTEN, 8'h0F);
    for (int l = 0; l < 4; l++)
    begin
      quiet();
      wr(ADDR_CONST_OUT, {2'b00, 2'(l), 4'h1});
      wr(ADDR_RUN_SOURCE, 8'h81);
      take(s);
      chk(32'(tone_running), 32'h1);
      chk(32'(s), {7'h0, DCV[l], 1'b1});
    end
    $display("test constant done");
    wr(ADDR_CONST_OUT, 8'h00);
    wr(ADDR_F1_LOW, 8'h34);
    wr(ADDR_F1_HIGH, 8'h12);
    wr(ADDR_F2_LOW, 8'hCD);
    wr(ADDR_F2_HIGH, 8'hAB);
    for (int m = 0; m < 3; m++)
    begin
      quiet();
      wr(ADDR_ATTEN, 8'(m * 5));
      stall = 1'b1;
      wr(ADDR_RUN_SOURCE, 8'h80 | 8'(m));
      // A long stall fills the FIFO; the sequence must resume without a gap.
      repeat (40) @(negedge sys_clk);
      stall = 1'b0;
      for (int k = 0; k < 24; k++)
      begin
        take(s);
        ev = (m == 0) ? ref_sine(24'(k * 'h1234)) + ref_sine(24'(k * 'hABCD)) :
             (m == 1) ? ref_sine(24'(k * 'h1234)) : ref_sine(24'(k * 'hABCD));
        chk(32'(s), {7'h0, ref_att(ev, 4'(m * 5)), 1'b0});
      end
    end
    $display("test sine done");
    quiet();
    wr(ADDR_ATTEN, 8'h00);
    wr(ADDR_F1_LOW, 8'hFF);
    wr(ADDR_F1_HIGH, 8'hFF);
    wr(ADDR_RUN_SOURCE, 8'h83);
    repeat (300) @(negedge sys_clk);
    snk.got_q.delete();
    take(s);
    chk(32'(s.value), 32'h0020_0000);
    rd(ADDR_RUN_SOURCE, d);
    chk(32'(d), 32'h0000_00C3);
    $display("test ramp done");
    wr(ADDR_RUN_SOURCE, 8'h81);
    for (int p = 1; p < 3; p++)
    begin
      prbs_sample = 24'h12_3450 | 24'(p);
      prbs_enable = 2'(p);
      repeat (30) @(negedge sys_clk);
      snk.got_q.delete();
      take(s);
      chk(32'(s), {7'h0, 24'h12_3450 | 24'(p), 1'b0});
    end
    $display("test priority done");
    print_verdict();
  end
endmodule // testbench
